// *** dv/dtc_carrier_model.sv ***
// Carrier source standing in for the demodulation input pin.
// Assumes the bench sets the wanted level just after a clock edge.
`timescale 1ns/1ps
module dtc_carrier_model
(
   input wire logic pclk,
   input wire logic drive_level,
   output logic carrier_in
);
   logic level_q = 1'b0;

   // Pin is always driven, so it never floats between bursts
   always @(posedge pclk)
   begin
      level_q <= drive_level;
   end

   assign carrier_in = level_q;
endmodule

// *** dv/dtc_dual_timer_properties.sv ***
// Port checker for the dual timer control block.
// Assumes the design top and its package are compiled first.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_dual_timer_properties
   import dtc_pkg::*;
#(
   parameter int T8_W = 8,
   parameter int T16_W = 16,
   parameter int PRE_W = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [5:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic eight_bit_wave,
   input wire logic wave_output_pin,
   input wire dtc_irq_t irq
);
   logic wr;
   logic sel_q, latch_q, init8_q, run8_q, ie8_q, ie16_q, cap_q;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ==========
   // Shadows of written control bits
   assign wr = psel && penable && pwrite && pready && paddr[1:0] == 2'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {sel_q, latch_q, init8_q, run8_q, ie8_q, ie16_q, cap_q} <= '0;
      end
      else if (wr && paddr[5:2] == `DTC_IDX_CTRL16)
      begin
         {cap_q, ie16_q, sel_q} <= pwdata[2:0];
      end
      else if (wr && paddr[5:2] == `DTC_IDX_CTRL8)
      begin
         run8_q <= pwdata[7];
         ie8_q <= pwdata[1];
      end
      else if (wr && paddr[5:2] == `DTC_IDX_SHARED)
      begin
         latch_q <= pwdata[7];
         init8_q <= pwdata[1];
      end
   end

   // ==========
   // Properties
   property p_pin_latch;
      !sel_q && $stable(sel_q) && $stable(latch_q)
         |=> wave_output_pin == $past(latch_q);
   endproperty
   a_pin_latch: assert property (p_pin_latch)
      else $error("pin not following port latch");

   property p_exp_gate;
      irq.expiry |-> ie16_q || $past(ie16_q);
   endproperty
   a_exp_gate: assert property (p_exp_gate)
      else $error("expiry interrupt while disabled");

   property p_cap_gate;
      irq.capture |-> cap_q || $past(cap_q);
   endproperty
   a_cap_gate: assert property (p_cap_gate)
      else $error("capture interrupt while disabled");

   property p_irq8_gate;
      irq.eight_bit |-> ie8_q || $past(ie8_q);
   endproperty
   a_irq8_gate: assert property (p_irq8_gate)
      else $error("eight bit interrupt while disabled");

   property p_irq8_pulse;
      irq.eight_bit |=> !irq.eight_bit;
   endproperty
   a_irq8_pulse: assert property (p_irq8_pulse)
      else $error("eight bit interrupt too long");

   property p_exp_pulse;
      irq.expiry |=> !irq.expiry;
   endproperty
   a_exp_pulse: assert property (p_exp_pulse)
      else $error("expiry interrupt too long");

   // Enable from stopped shows the initial level first
   property p_wave_init;
      wr && paddr[5:2] == `DTC_IDX_CTRL8 && pwdata[7] && !run8_q
         |-> ##[2:4] eight_bit_wave == $past(init8_q, 2);
   endproperty
   a_wave_init: assert property (p_wave_init)
      else $error("eight bit wave missed initial level");

   property p_irq_after_reset;
      $rose(presetn) |-> irq == 3'h0;
   endproperty
   a_irq_after_reset: assert property (p_irq_after_reset)
      else $error("interrupt at reset release");

   c_irq8: cover property (irq.eight_bit);
   c_cap: cover property (irq.capture);
   c_pin: cover property (sel_q && !wave_output_pin && latch_q);
endmodule

bind dtc_dual_timer dtc_dual_timer_properties #(
   .T8_W(T8_W),
   .T16_W(T16_W),
   .PRE_W(PRE_W)
) u_dtc_dual_timer_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .eight_bit_wave(eight_bit_wave), .wave_output_pin(wave_output_pin),
   .irq(irq)
);

// *** dv/dual_timer_control_bench.sv ***
// Self-checking bench for the dual timer control block.
// Assumes the design, its package and the carrier model.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dual_timer_control_bench;
   import dtc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [5:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, level = 0, carrier_in, w8_q, w16_q;
   logic eight_bit_wave, sixteen_bit_wave, wave_output_pin;
   dtc_irq_t irq;
   int miscompares = 0, tests_run = 0, n, t8, t16;
   int n_irq8 = 0, n_cap = 0, n_exp = 0, n_tg8 = 0, n_tg16 = 0;

   always #2.5 pclk = ~pclk;

   dtc_dual_timer u_dtc_dual_timer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .carrier_in(carrier_in),
      .eight_bit_wave(eight_bit_wave), .sixteen_bit_wave(sixteen_bit_wave),
      .wave_output_pin(wave_output_pin), .irq(irq));
   dtc_carrier_model u_dtc_carrier_model (.pclk(pclk),
      .drive_level(level), .carrier_in(carrier_in));

   // Event tally
   always @(posedge pclk)
   begin
      n_irq8 <= n_irq8 + (irq.eight_bit === 1'b1);
      n_cap <= n_cap + (irq.capture === 1'b1);
      n_exp <= n_exp + (irq.expiry === 1'b1);
      w8_q <= eight_bit_wave;
      w16_q <= sixteen_bit_wave;
      n_tg8 <= n_tg8 + (presetn && eight_bit_wave !== w8_q);
      n_tg16 <= n_tg16 + (presetn && sixteen_bit_wave !== w16_q);
   end

   // ==========
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [3:0] i,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [3:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h00);
      chk(rd, {24'h00_0000, e});
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // Cycles until the chosen wave changes
   task automatic phase(input logic s);
      logic v;
      v = s ? sixteen_bit_wave : eight_bit_wave;
      n = 0;
      do
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      while (n < 2000 && v === (s ? sixteen_bit_wave : eight_bit_wave));
   endtask

   task automatic edge_in();
      level <= 1'b1;
      tick(10);
      level <= 1'b0;
      tick(10);
   endtask

   task automatic wrap_up();
      if (miscompares == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      wrap_up();
   end

   // ==========
   // Sequence
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++)
         rdc(i[3:0], 8'h00);
      apb(1'b1, 4'hA, 8'hFF);
      apb(1'b0, 4'hA, 8'h00);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, `DTC_IDX_SHARED, 8'h80);
      tick(4);
      chk(wave_output_pin, 32'h1);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h01);
      tick(4);
      chk(wave_output_pin, 32'h0);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h00);
      // Single pass from the high reload
      apb(1'b1, `DTC_IDX_SHARED, 8'h02);
      apb(1'b1, `DTC_IDX_RL8_HI, 8'h03);
      apb(1'b1, `DTC_IDX_CTRL8, 8'hC2);
      tick(20);
      chk(eight_bit_wave, 32'h0);
      chk(n_irq8, 32'h1);
      rdc(`DTC_IDX_CTRL8, 8'h62);
      apb(1'b1, `DTC_IDX_CTRL8, 8'h20);
      rdc(`DTC_IDX_CTRL8, 8'h00);
      // Modulo-N with a late reload change
      apb(1'b1, `DTC_IDX_SHARED, 8'h00);
      apb(1'b1, `DTC_IDX_RL8_LO, 8'h02);
      apb(1'b1, `DTC_IDX_RL8_HI, 8'h00);
      apb(1'b1, `DTC_IDX_CTRL8, 8'h82);
      phase(1'b0);
      tick(3);
      chk(n_irq8, 32'h1);
      apb(1'b1, `DTC_IDX_RL8_LO, 8'h05);
      phase(1'b0);
      phase(1'b0);
      chk(n, 32'h5);
      phase(1'b0);
      chk(n, 32'h100);
      tick(3);
      chk(n_irq8, 32'h4);
      apb(1'b1, `DTC_IDX_CTRL8, 8'h20);
      // Prescale codes in repeating mode, then a one-shot expiry
      apb(1'b1, `DTC_IDX_RL16_LO, 8'h03);
      apb(1'b1, `DTC_IDX_RL16_HI, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, `DTC_IDX_CTRL16, {3'h4, c[1:0], 3'h0});
         phase(1'b1);
         phase(1'b1);
         chk(n, 32'h3 << c);
         apb(1'b1, `DTC_IDX_CTRL16, 8'h00);
      end
      apb(1'b1, `DTC_IDX_CTRL16, 8'hC2);
      tick(20);
      chk(n_exp, 32'h1);
      rdc(`DTC_IDX_CTRL16, 8'h62);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h20);
      rdc(`DTC_IDX_CTRL16, 8'h00);
      // Lockstep start and stop, then ping-pong hand-over ended by mode bits 00
      apb(1'b1, `DTC_IDX_SYNC, 8'h20);
      apb(1'b1, `DTC_IDX_SYNC, 8'hA0);
      rdc(`DTC_IDX_SYNC, 8'hE0);
      apb(1'b1, `DTC_IDX_SYNC, 8'h20);
      rdc(`DTC_IDX_SYNC, 8'h20);
      apb(1'b1, `DTC_IDX_SYNC, 8'h00);
      apb(1'b1, `DTC_IDX_CTRL8, 8'h20);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h60);
      apb(1'b1, `DTC_IDX_SHARED, 8'h04);
      apb(1'b1, `DTC_IDX_RL8_LO, 8'h04);
      t8 = n_tg8;
      t16 = n_tg16;
      apb(1'b1, `DTC_IDX_CTRL8, 8'hC0);
      tick(100);
      chk(n_tg8 - t8 >= 2 && n_tg16 - t16 >= 2, 32'h1);
      apb(1'b1, `DTC_IDX_SHARED, 8'h00);
      tick(40);
      t8 = n_tg8 + n_tg16;
      tick(60);
      chk(n_tg8 + n_tg16 - t8, 32'h0);
      // Edge capture on rising edges
      apb(1'b1, `DTC_IDX_CTRL8, 8'h20);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h20);
      apb(1'b1, `DTC_IDX_RL16_LO, 8'h00);
      apb(1'b1, `DTC_IDX_RL16_HI, 8'h10);
      apb(1'b1, `DTC_IDX_SHARED, 8'h50);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h84);
      edge_in();
      edge_in();
      chk(n_cap, 32'h2);
      apb(1'b1, `DTC_IDX_CTRL16, 8'hC4);
      edge_in();
      edge_in();
      chk(n_cap, 32'h3);
      // Falling edges only, so the re-armed capture waits for the fall
      apb(1'b1, `DTC_IDX_SHARED, 8'h60);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h84);
      apb(1'b1, `DTC_IDX_CTRL16, 8'hC4);
      edge_in();
      chk(n_cap, 32'h4);
      apb(1'b1, `DTC_IDX_CTRL8, 8'hC0);
      tick(20);
      chk(n_cap, 32'h5);
      // Wrap of the demodulating counter
      apb(1'b1, `DTC_IDX_CTRL16, 8'h20);
      apb(1'b1, `DTC_IDX_RL16_LO, 8'h04);
      apb(1'b1, `DTC_IDX_RL16_HI, 8'h00);
      apb(1'b1, `DTC_IDX_CTRL16, 8'h82);
      tick(30);
      chk(n_exp, 32'h2);
      wrap_up();
   end
endmodule

// *** hw/dtc_dual_timer.sv ***
// Dual chained down-counter: 8-bit and 16-bit timers with waveform,
// ping-pong and capture logic behind an APB slave.
// Assumes one clock pclk and an asynchronous active-low reset.
//
// Contract
// R1: Run bit 7 of the 16-bit control reads running; write starts/stops.
// R2: Transmit: one-shot 0 reloads at terminal count, 1 stops there.
// R3: Demod: one-shot 0 captures every edge; 1 only the first edge.
// R4: Flag bit 5 set on 16-bit terminal count; write 1 clears it.
// R5: Prescale code 00..11 divides clock by 1, 2, 4 or 8.
// R6: Capture interrupt allow bit 2 requests interrupt on each capture.
// R7: Expiry interrupt allow bit 1 requests interrupt at terminal count.
// R8: Pin select bit 0 routes port latch or 16-bit wave; resets 0.
// R9: Sync register holds both run bits and a lockstep start bit.
// R10: 8-bit enable sets initial level, loads low or high reload.
// R11: 8-bit single pass stops at 0, toggles, flags, interrupts.
// R12: Modulo-N: first terminal toggles quietly; later ones flag too.
// R13: Reload writes allowed anytime; used only at the next load.
// R14: Initial count 0 gives a full 256-state count.
// R15: Software avoids writes at load time and an initial count of 1.
// R16: Demod one-shot: 8-bit timeout captures 16-bit count, no reload.
// R17: Writing one-shot 0 then 1 re-arms capture on next edge.
// R18: Demod 16-bit wraps from 0 to FFFFh, flags and interrupts.
// R19: Software uses ping-pong only in transmit single-pass mode.
// R20: Ping-pong: each terminal count stops one timer, starts other.
// R21: Ping-pong bits written 00 end the hand-over.
// R22: Software stops timers and clears flags before ping-pong.
`timescale 1ns/1ps
`include "dtc_params.svh"

module dtc_dual_timer
   import dtc_pkg::*;
#(
   parameter int T8_W = 8,
   parameter int T16_W = 16,
   parameter int PRE_W = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [5:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic carrier_in,
   output logic eight_bit_wave,
   output logic sixteen_bit_wave,
   output logic wave_output_pin,
   output dtc_irq_t irq
);

   // Byte-wide register lanes fix the widths
   if (T8_W != 8 || T16_W != 16 || PRE_W != 3)
   begin : g_check
      $error("dtc_dual_timer: unsupported widths");
   end

   // ==========================================================
   // Helpers
   function automatic logic at_one(input logic [15:0] v);
      at_one = (v == 16'h0001);
   endfunction

   function automatic logic pre_tick(input logic [2:0] c,
                                     input logic [1:0] s);
      case (s)
         2'h0: pre_tick = 1'b1;
         2'h1: pre_tick = c[0];
         2'h2: pre_tick = &c[1:0];
         default: pre_tick = &c;
      endcase
   endfunction

   function automatic logic hit(input logic [3:0] a, input logic [3:0] i);
      hit = (a == i);
   endfunction

   // ==========================================================
   // Register state
   logic t8_run, t8_single, t8_flag, t8_toie, t8_first, wave8;
   logic t16_run, t16_oneshot, t16_flag, capie, toie16, pin_sel;
   logic sync_mode, armed, wave16, cin_s1, cin_s2, cin_s3;
   logic [1:0] pre_sel;
   logic [2:0] pre_cnt;
   logic [7:0] t8_cnt, rl8_lo, rl8_hi, rl16_lo, rl16_hi, rd;
   logic [15:0] t16_cnt, cap;
   dtc_shared_t shared;

   // ==========================================================
   // APB decode
   logic [3:0] idx;
   logic [7:0] wb;
   logic mapped, wr, wr_c0, wr_c1, wr_c2, wr_c3;

   assign idx = paddr[5:2];
   assign mapped = (paddr[1:0] == 2'h0) && (idx <= `DTC_IDX_CAP_HI);
   assign wr = psel && penable && pwrite && mapped;
   assign wb = pwdata[7:0];
   assign wr_c0 = wr && hit(idx, `DTC_IDX_CTRL8);
   assign wr_c1 = wr && hit(idx, `DTC_IDX_SHARED);
   assign wr_c2 = wr && hit(idx, `DTC_IDX_CTRL16);
   assign wr_c3 = wr && hit(idx, `DTC_IDX_SYNC);
   assign pready = 1'b1;

   // ==========================================================
   // Run requests
   logic c3_run8, c3_run16, run8_wr, run8_val, run16_wr, run16_val;

   // R9: lockstep start of both
   assign c3_run8 = wb[`DTC_RUN8_BIT] | (sync_mode & wb[`DTC_RUN_BIT]);
   assign c3_run16 = wb[`DTC_RUN_BIT] | (sync_mode & wb[`DTC_RUN8_BIT]);
   assign run8_wr = wr_c0 | wr_c3;
   assign run8_val = wr_c3 ? c3_run8 : wb[`DTC_RUN_BIT];
   assign run16_wr = wr_c2 | wr_c3;
   assign run16_val = wr_c3 ? c3_run16 : wb[`DTC_RUN_BIT];

   // ==========================================================
   // Events
   logic pp_on, t8_tc, t8_ev, t16_tick, t16_tc, t16_wrap, rise, fall;
   logic edge_hit, edge_take, cap_ev, start8, start16;
   logic [15:0] rl16;

   // R21: hand-over only while the mode bits select it
   assign pp_on = !shared.demod && (shared.pp_mode == `DTC_PP_ON);
   assign rl16 = {rl16_hi, rl16_lo};
   assign t8_tc = t8_run && at_one({8'h00, t8_cnt});
   // R12: first modulo-N terminal count is quiet
   assign t8_ev = t8_tc && (t8_single || !t8_first);
   // R5: prescaled tick
   assign t16_tick = t16_run && pre_tick(pre_cnt, pre_sel);
   assign t16_tc = t16_tick && !shared.demod && at_one(t16_cnt);
   assign t16_wrap = t16_tick && shared.demod && (t16_cnt == 16'h0000);
   assign rise = cin_s2 && !cin_s3;
   assign fall = !cin_s2 && cin_s3;
   assign edge_hit = (shared.edge_sel[0] && rise)
                   || (shared.edge_sel[1] && fall);
   // R3: one-shot takes only an armed edge
   assign edge_take = shared.demod && t16_run && edge_hit
                    && (!t16_oneshot || armed);
   // R16: 8-bit timeout captures in one-shot demod
   assign cap_ev = edge_take || (shared.demod && t16_oneshot
                    && t16_run && t8_ev);
   // R20: terminal count of one timer starts the other
   assign start8 = (run8_wr && run8_val && !t8_run)
                 || (pp_on && t16_tc);
   assign start16 = (run16_wr && run16_val && !t16_run)
                  || (pp_on && t8_tc);

   // ==========================================================
   // Carrier input synchroniser and edge history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {cin_s1, cin_s2, cin_s3} <= 3'h0;
      else
      begin
         cin_s1 <= carrier_in;
         cin_s2 <= cin_s1;
         cin_s3 <= cin_s2;
      end
   end

   // ==========================================================
   // Software-owned control fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {t8_single, t8_toie, t16_oneshot, capie} <= 4'h0;
         {toie16, pin_sel, sync_mode} <= 3'h0;
         shared <= `DTC_RST_BYTE;
         pre_sel <= 2'h0;
         {rl8_lo, rl8_hi} <= {`DTC_RST_BYTE, `DTC_RST_BYTE};
         {rl16_lo, rl16_hi} <= {`DTC_RST_BYTE, `DTC_RST_BYTE};
      end
      else
      begin
         if (wr_c0)
         begin
            t8_single <= wb[`DTC_ONESHOT_BIT];
            t8_toie <= wb[`DTC_TOIE_BIT];
         end
         if (wr_c1)
            shared <= wb;
         if (wr_c2)
         begin
            t16_oneshot <= wb[`DTC_ONESHOT_BIT];
            pre_sel <= wb[`DTC_PRE_MSB:`DTC_PRE_LSB];
            capie <= wb[`DTC_CAPIE_BIT];
            toie16 <= wb[`DTC_TOIE_BIT];
            // R8: pin source select
            pin_sel <= wb[`DTC_PINSEL_BIT];
         end
         if (wr_c3)
            sync_mode <= wb[`DTC_SYNC_BIT];
         // R13: stored now, used at next load
         if (wr && hit(idx, `DTC_IDX_RL8_LO))
            rl8_lo <= wb;
         if (wr && hit(idx, `DTC_IDX_RL8_HI))
            rl8_hi <= wb;
         if (wr && hit(idx, `DTC_IDX_RL16_LO))
            rl16_lo <= wb;
         if (wr && hit(idx, `DTC_IDX_RL16_HI))
            rl16_hi <= wb;
      end
   end

   // ==========================================================
   // Eight-bit timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {t8_run, t8_first, wave8} <= 3'h0;
         t8_cnt <= `DTC_RST_BYTE;
      end
      else if (start8)
      begin
         // R10: initial level picks the reload
         t8_run <= 1'b1;
         wave8 <= shared.init8;
         t8_cnt <= shared.init8 ? rl8_hi : rl8_lo;
         t8_first <= 1'b1;
      end
      else if (run8_wr && !run8_val)
         t8_run <= 1'b0;
      else if (t8_tc)
      begin
         wave8 <= !wave8;
         t8_first <= 1'b0;
         // R11: single pass stops after toggling
         if (t8_single || pp_on)
            t8_run <= 1'b0;
         else
            t8_cnt <= wave8 ? rl8_lo : rl8_hi;
      end
      else if (t8_run)
         // R14: 0 decrements to FFh, so 256 states
         t8_cnt <= t8_cnt - 8'h01;
   end

   // ==========================================================
   // Prescaler; restarted so lockstep timers share phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_cnt <= `DTC_RST_PRE;
      else if (start16)
         pre_cnt <= `DTC_RST_PRE;
      else
         pre_cnt <= pre_cnt + 3'h1;
   end

   // ==========================================================
   // Sixteen-bit timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {t16_run, wave16} <= 2'h0;
         t16_cnt <= `DTC_RST_WORD;
      end
      else if (start16)
      begin
         // R1: write 1 starts counting
         t16_run <= 1'b1;
         wave16 <= shared.init16;
         t16_cnt <= rl16;
      end
      else if (run16_wr && !run16_val)
         // R1: write 0 stops
         t16_run <= 1'b0;
      else if (edge_take)
         t16_cnt <= rl16;
      else if (t16_tc)
      begin
         wave16 <= !wave16;
         // R2: one-shot stops, modulo-N reloads
         if (t16_oneshot)
            t16_run <= 1'b0;
         else
            t16_cnt <= rl16;
      end
      else if (t16_tick)
         // R18: demod count wraps from 0 to FFFFh
         t16_cnt <= t16_cnt - 16'h0001;
   end

   // ==========================================================
   // Edge arming
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         armed <= 1'b0;
      else if (start16)
         armed <= 1'b1;
      // R17: one-shot bit taken from 0 to 1 re-arms
      else if (wr_c2 && wb[`DTC_ONESHOT_BIT] && !t16_oneshot)
         armed <= 1'b1;
      else if (edge_take)
         armed <= 1'b0;
   end

   // ==========================================================
   // Capture and flags; a set wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cap <= `DTC_RST_WORD;
      else if (cap_ev)
         cap <= t16_cnt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {t8_flag, t16_flag} <= 2'h0;
      else
      begin
         t8_flag <= (t8_flag && !(wr_c0 && wb[`DTC_FLAG_BIT])) || t8_ev;
         // R4: set on terminal count, write 1 clears
         t16_flag <= (t16_flag && !(wr_c2 && wb[`DTC_FLAG_BIT]))
                   || t16_tc || t16_wrap;
      end
   end

   // ==========================================================
   // Interrupt requests, one-cycle pulses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 3'h0;
      else
      begin
         irq.eight_bit <= t8_toie && t8_ev;
         // R6: request on each capture
         irq.capture <= capie && cap_ev;
         // R7: request on expiry
         irq.expiry <= toie16 && (t16_tc || t16_wrap);
      end
   end

   // ==========================================================
   // Pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {eight_bit_wave, sixteen_bit_wave, wave_output_pin} <= 3'h0;
      else
      begin
         eight_bit_wave <= wave8;
         sixteen_bit_wave <= wave16;
         // R8: latch or waveform onto the pin
         wave_output_pin <= pin_sel ? wave16 : shared.port_latch;
      end
   end

   // ==========================================================
   // Read path, sampled in the setup cycle
   always_comb
   begin
      case (idx)
         `DTC_IDX_CTRL8: rd = {t8_run, t8_single, t8_flag, 3'h0,
                               t8_toie, 1'b0};
         `DTC_IDX_SHARED: rd = shared;
         `DTC_IDX_CTRL16: rd = {t16_run, t16_oneshot, t16_flag,
                                pre_sel, capie, toie16, pin_sel};
         `DTC_IDX_SYNC: rd = {t16_run, t8_run, sync_mode, 5'h00};
         `DTC_IDX_RL8_LO: rd = rl8_lo;
         `DTC_IDX_RL8_HI: rd = rl8_hi;
         `DTC_IDX_RL16_LO: rd = rl16_lo;
         `DTC_IDX_RL16_HI: rd = rl16_hi;
         `DTC_IDX_CAP_LO: rd = cap[7:0];
         `DTC_IDX_CAP_HI: rd = cap[15:8];
         default: rd = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata <= mapped ? {24'h00_0000, rd} : 32'h0000_0000;
         pslverr <= !mapped;
      end
   end

endmodule

// *** hw/dtc_params.svh ***
// Constants for the dual timer control block: register indices,
// bit positions and reset values. Definitions only.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register indices; byte address is four times the index
`define DTC_IDX_CTRL8   4'h0
`define DTC_IDX_SHARED  4'h1
`define DTC_IDX_CTRL16  4'h2
`define DTC_IDX_SYNC    4'h3
`define DTC_IDX_RL8_LO  4'h4
`define DTC_IDX_RL8_HI  4'h5
`define DTC_IDX_RL16_LO 4'h6
`define DTC_IDX_RL16_HI 4'h7
`define DTC_IDX_CAP_LO  4'h8
`define DTC_IDX_CAP_HI  4'h9

// Control bit positions
`define DTC_RUN_BIT     7
`define DTC_ONESHOT_BIT 6
`define DTC_FLAG_BIT    5
`define DTC_PRE_MSB     4
`define DTC_PRE_LSB     3
`define DTC_CAPIE_BIT   2
`define DTC_TOIE_BIT    1
`define DTC_PINSEL_BIT  0
`define DTC_RUN8_BIT    6
`define DTC_SYNC_BIT    5

// Ping-pong select code
`define DTC_PP_ON 2'h1

// Reset values
`define DTC_RST_BYTE 8'h00
`define DTC_RST_WORD 16'h0000
`define DTC_RST_PRE  3'h0

`endif

// *** hw/dtc_pkg.sv ***
// Types shared by the dual timer control block.
// Assumes the constants header is compiled alongside.
package dtc_pkg;

   typedef struct packed {
      logic port_latch;
      logic demod;
      logic [1:0] edge_sel;
      logic [1:0] pp_mode;
      logic init8;
      logic init16;
   } dtc_shared_t;

   typedef struct packed {
      logic eight_bit;
      logic capture;
      logic expiry;
   } dtc_irq_t;

endpackage
